// ### papc_pkg.sv
// constants and carrier types for the two-port negotiation and configuration block
package papc_pkg;
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h01;
   localparam logic [4:0] REG_ADV = 5'h04;
   localparam logic [4:0] REG_LPA = 5'h05;
   localparam int CTRL_SPEED = 13;
   localparam int CTRL_NEG_EN = 12;
   localparam int CTRL_RESTART = 9;
   localparam int CTRL_FULL = 8;
   localparam int STAT_DONE = 5;
   localparam int STAT_RFAULT = 4;
   localparam int STAT_LINK = 2;
   localparam int ADV_ACK = 14;
   localparam int ADV_RFAULT = 13;
   localparam int ADV_PAUSE = 10;
   localparam int ADV_100F = 8;
   localparam int ADV_100H = 7;
   localparam int ADV_10F = 6;
   localparam int ADV_10H = 5;
   localparam logic [15:0] STAT_FIXED = 16'hf809;
   localparam logic [15:0] ADV_RESET = 16'h05e1;
   localparam logic [15:0] CTRL_RESET = 16'h3100;
   // phy address 5'h10 serves port 0, 5'h11 port 1
   localparam logic [4:0] PHY_BASE = 5'h10;
   localparam logic [8:0] PROM_CMD = 9'h185;
   localparam int PROM_IRQ_BIT = 15;
   localparam logic [4:0] PROM_LAST = 5'h18;
   localparam logic [5:0] PRE_ONES = 6'h20;
   localparam logic [5:0] HDR_BITS = 6'h0d;
   localparam logic [5:0] RD_LAST = 6'h11;
   localparam logic [5:0] WR_LAST = 6'h11;
   localparam int CLK_PERIOD_NS = 5;
   localparam int FLP_BURST_NS = 16000000;
   localparam int FLP_BURST_CYC = FLP_BURST_NS / CLK_PERIOD_NS;
   localparam int PROM_HALF_NS = 1000;
   localparam int PROM_HALF_CYC = (PROM_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef struct packed {
      logic neg_off;
      logic half_pref;
      logic slow_pref;
      logic pause_off;
   } papc_pins_s;
   typedef struct packed {
      logic speed100;
      logic full;
      logic pause;
   } papc_mode_s;
   typedef enum logic [1:0] {
      NEG_IDLE = 2'b00,
      NEG_ABIL = 2'b01,
      NEG_ACK = 2'b10,
      NEG_DONE = 2'b11
   } papc_neg_e;
   typedef enum logic [1:0] {
      MD_PRE = 2'b00,
      MD_HDR = 2'b01,
      MD_RD = 2'b10,
      MD_WR = 2'b11
   } papc_mdio_e;
endpackage : papc_pkg

// ### papc_neg.sv
// per-port negotiation engine exchanging ability words with the link partner
`timescale 1ns/10ps
module papc_neg #(
   parameter int BURST_CYC = papc_pkg::FLP_BURST_CYC
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic neg_en,
   input wire logic restart,
   input wire logic [15:0] adv,
   input wire logic link_ok,
   input wire logic rx_valid,
   input wire logic [15:0] rx_word,
   output logic tx_valid,
   output logic [15:0] tx_word,
   output logic [15:0] lpa,
   output logic done
);
   typedef struct packed {
      papc_pkg::papc_neg_e st;
      logic [21:0] tmr;
      logic tx_valid;
      logic [15:0] tx_word;
      logic [15:0] lpa;
      logic done;
   } papc_neg_s;
   papc_neg_s q, d;
   localparam logic [21:0] TMR_LAST = 22'(BURST_CYC - 1);

   always_comb
   begin
      d = q;
      d.tx_valid = 1'b0;
      if (q.st == papc_pkg::NEG_ABIL || q.st == papc_pkg::NEG_ACK)
      begin
         d.tmr = (q.tmr == TMR_LAST) ? 22'h000000 : q.tmr + 22'h000001;
         if (q.tmr == 22'h000000)
         begin
            d.tx_valid = 1'b1;
            d.tx_word = adv;
            d.tx_word[papc_pkg::ADV_ACK] = (q.st == papc_pkg::NEG_ACK);
         end
      end
      case (q.st)
         papc_pkg::NEG_IDLE:
         begin
            d.tmr = 22'h000000;
            if (neg_en)
               d.st = papc_pkg::NEG_ABIL;
         end
         papc_pkg::NEG_ABIL:
            if (rx_valid)
            begin
               d.lpa = rx_word;
               d.st = papc_pkg::NEG_ACK;
            end
         papc_pkg::NEG_ACK:
            if (rx_valid && rx_word[papc_pkg::ADV_ACK])
            begin
               d.lpa = rx_word;
               d.done = 1'b1;
               d.st = papc_pkg::NEG_DONE;
            end
         papc_pkg::NEG_DONE:
            // a lost link starts a fresh exchange
            if (!link_ok)
            begin
               d.done = 1'b0;
               d.tmr = 22'h000000;
               d.st = papc_pkg::NEG_ABIL;
            end
         default:
            d.st = papc_pkg::NEG_IDLE;
      endcase
      if (restart)
      begin
         d.st = papc_pkg::NEG_ABIL;
         d.tmr = 22'h000000;
         d.done = 1'b0;
      end
      if (!neg_en)
      begin
         d.st = papc_pkg::NEG_IDLE;
         d.done = 1'b0;
         // a burst due in the same cycle as the disable must not leave
         d.tx_valid = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tx_valid = q.tx_valid;
   assign tx_word = q.tx_word;
   assign lpa = q.lpa;
   assign done = q.done;

   done_in_state_a: assert property (@(posedge clock) disable iff (!rstn)
      done |-> q.st == papc_pkg::NEG_DONE) else $error("done flag outside done state");
   neg_off_idle_a: assert property (@(posedge clock) disable iff (!rstn)
      !neg_en |=> !done && !tx_valid) else $error("negotiation ran while disabled");
   burst_adv_a: assert property (@(posedge clock) disable iff (!rstn)
      tx_valid |-> (tx_word[12:0] == $past(adv[12:0])) ##1 !tx_valid)
      else $error("burst word differs from advertisement");
endmodule : papc_neg

// ### papc_top.sv
// two-port negotiation, configuration straps and shared management/PROM pins
`timescale 1ns/10ps
module papc_top #(
   parameter int BURST_CYC = papc_pkg::FLP_BURST_CYC
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic power_on_rc_input,
   input wire logic test_mode_strap,
   input wire logic prom_select_iface_choice_i,
   output logic prom_select_iface_choice_o,
   output logic prom_select_iface_choice_oe_n,
   input wire logic shared_serial_clock_i,
   output logic shared_serial_clock_o,
   output logic shared_serial_clock_oe_n,
   input wire logic shared_serial_data_i,
   output logic shared_serial_data_o,
   output logic shared_serial_data_oe_n,
   input wire logic prom_data_return,
   input wire papc_pkg::papc_pins_s port0_pins,
   input wire papc_pkg::papc_pins_s port1_pins,
   input wire logic auto_crossover_on,
   input wire logic port0_manual_crossover,
   input wire logic [1:0] link_ok,
   input wire logic [1:0] flp_rx_valid,
   input wire logic [15:0] flp_rx_word0,
   input wire logic [15:0] flp_rx_word1,
   output logic [1:0] flp_tx_valid,
   output logic [15:0] flp_tx_word0,
   output logic [15:0] flp_tx_word1,
   output papc_pkg::papc_mode_s port0_mode,
   output papc_pkg::papc_mode_s port1_mode,
   output logic crossover_auto,
   output logic port0_crossover_forced,
   output logic test_mode,
   output logic internal_reset_n,
   output logic interrupt_o,
   output logic interrupt_oe_n
);
   typedef struct packed {
      logic rc_meta;
      logic rst_n;
      logic rst_prev;
      logic test_mode;
      logic port_interface_choice;
      logic irq_pol;
      logic irq_pend;
      logic [1:0] done_prev;
      logic [1:0] link_prev;
      logic [1:0][15:0] ctrl;
      logic [1:0][15:0] adv;
      logic [1:0] restart;
      papc_pkg::papc_mdio_e mst;
      logic [5:0] cnt;
      logic [15:0] sh;
      logic [4:0] reg_a;
      logic port_sel;
      logic sdc_prev;
      logic prom_busy;
      logic [7:0] pdiv;
      logic [4:0] pbit;
      logic eck;
      logic ecs;
      logic edi;
      logic [2:0] oe_n;
      logic sdo;
      logic [1:0] mode_speed;
      logic [1:0] mode_full;
      logic [1:0] mode_pause;
      logic xo_auto;
      logic xo_forced;
      logic int_o;
   } papc_top_s;
   papc_top_s q, n;
   logic [1:0][15:0] lpa;
   logic [1:0] done;
   logic [1:0][15:0] lpa_tx;
   localparam logic [7:0] PDIV_LAST = 8'(papc_pkg::PROM_HALF_CYC - 1);

   // common mode from the abilities both ends share
   function automatic logic [1:0] resolve(input logic [15:0] a, input logic [15:0] b);
      logic [15:0] c;
      c = a & b;
      if (c[papc_pkg::ADV_100F])
         resolve = 2'b11;
      else if (c[papc_pkg::ADV_100H])
         resolve = 2'b10;
      else if (c[papc_pkg::ADV_10F])
         resolve = 2'b01;
      else
         resolve = 2'b00;
   endfunction : resolve

   function automatic logic [15:0] rd_reg(input logic p, input logic [4:0] a,
      input papc_top_s s, input logic [1:0][15:0] lp, input logic [1:0] dn);
      rd_reg = 16'h0000;
      case (a)
         papc_pkg::REG_CTRL: rd_reg = s.ctrl[p];
         papc_pkg::REG_STAT:
         begin
            rd_reg = papc_pkg::STAT_FIXED;
            rd_reg[papc_pkg::STAT_DONE] = dn[p];
            rd_reg[papc_pkg::STAT_RFAULT] = dn[p] & lp[p][papc_pkg::ADV_RFAULT];
            rd_reg[papc_pkg::STAT_LINK] = link_ok[p];
         end
         papc_pkg::REG_ADV: rd_reg = s.adv[p];
         papc_pkg::REG_LPA: rd_reg = lp[p];
         default: rd_reg = 16'h0000;
      endcase
   endfunction : rd_reg

   // strap-derived defaults for one port
   function automatic logic [31:0] seed(input papc_pkg::papc_pins_s pn);
      logic [15:0] c;
      logic [15:0] a;
      c = papc_pkg::CTRL_RESET;
      a = papc_pkg::ADV_RESET;
      c[papc_pkg::CTRL_NEG_EN] = !pn.neg_off;
      c[papc_pkg::CTRL_SPEED] = !pn.slow_pref;
      c[papc_pkg::CTRL_FULL] = !pn.half_pref;
      if (pn.slow_pref)
      begin
         a[papc_pkg::ADV_100F] = 1'b0;
         a[papc_pkg::ADV_100H] = 1'b0;
      end
      if (pn.half_pref)
      begin
         a[papc_pkg::ADV_100F] = 1'b0;
         a[papc_pkg::ADV_10F] = 1'b0;
      end
      a[papc_pkg::ADV_PAUSE] = !pn.pause_off;
      seed = {c, a};
   endfunction : seed

   always_comb
   begin
      logic rel;
      logic edge_r;
      logic [1:0] rs;
      logic [31:0] s0;
      logic [31:0] s1;
      rel = 1'b0;
      edge_r = 1'b0;
      rs = 2'b00;
      s0 = seed(port0_pins);
      s1 = seed(port1_pins);
      n = q;
      n.rc_meta = power_on_rc_input;
      n.rst_n = q.rc_meta;
      n.rst_prev = q.rst_n;
      n.restart = 2'b00;
      n.done_prev = done;
      n.link_prev = link_ok;
      rel = q.rst_n & !q.rst_prev;
      if (rel)
      begin
         n.test_mode = test_mode_strap;
         n.port_interface_choice = prom_select_iface_choice_i;
         n.ctrl[0] = s0[31:16];
         n.adv[0] = s0[15:0];
         n.ctrl[1] = s1[31:16];
         n.adv[1] = s1[15:0];
         n.prom_busy = prom_select_iface_choice_i;
         n.ecs = prom_select_iface_choice_i;
         n.eck = 1'b0;
         n.pdiv = 8'h00;
         n.pbit = 5'h00;
         n.edi = papc_pkg::PROM_CMD[8];
      end
      // interrupt on negotiation done or link change; set wins over the status-read clear
      if (!q.prom_busy && q.port_interface_choice == 1'b0 && q.mst == papc_pkg::MD_RD
          && q.cnt == 6'h00 && q.reg_a == papc_pkg::REG_STAT)
         n.irq_pend = 1'b0;
      if ((done & ~q.done_prev) != 2'b00 || link_ok != q.link_prev)
         n.irq_pend = q.rst_n;
      // PROM read of word 5 for the interrupt polarity
      if (q.prom_busy)
      begin
         n.pdiv = (q.pdiv == PDIV_LAST) ? 8'h00 : q.pdiv + 8'h01;
         if (q.pdiv == PDIV_LAST)
         begin
            n.eck = !q.eck;
            if (!q.eck)
            begin
               if (q.pbit == 5'h09)
                  n.irq_pol = prom_data_return;
               n.pbit = q.pbit + 5'h01;
               if (q.pbit == papc_pkg::PROM_LAST)
               begin
                  n.prom_busy = 1'b0;
                  n.ecs = 1'b0;
                  n.eck = 1'b0;
               end
            end
            else if (q.pbit < 5'h09)
               n.edi = papc_pkg::PROM_CMD[4'h8 - q.pbit[3:0]];
            else
               n.edi = 1'b0;
         end
      end
      // management frame slave, sampled on rising shared clock
      n.sdc_prev = shared_serial_clock_i;
      edge_r = shared_serial_clock_i & !q.sdc_prev & !q.port_interface_choice;
      if (edge_r)
      begin
         case (q.mst)
            papc_pkg::MD_PRE:
               if (shared_serial_data_i)
                  n.cnt = (q.cnt == papc_pkg::PRE_ONES) ? q.cnt : q.cnt + 6'h01;
               else if (q.cnt == papc_pkg::PRE_ONES)
               begin
                  n.mst = papc_pkg::MD_HDR;
                  n.cnt = 6'h00;
               end
               else
                  n.cnt = 6'h00;
            papc_pkg::MD_HDR:
            begin
               n.sh = {q.sh[14:0], shared_serial_data_i};
               n.cnt = q.cnt + 6'h01;
               if (q.cnt == papc_pkg::HDR_BITS - 6'h01)
               begin
                  n.cnt = 6'h00;
                  n.reg_a = n.sh[4:0];
                  n.port_sel = n.sh[5];
                  n.mst = papc_pkg::MD_PRE;
                  if (n.sh[12] && n.sh[9:6] == papc_pkg::PHY_BASE[4:1])
                  begin
                     if (n.sh[11:10] == 2'b10)
                     begin
                        n.mst = papc_pkg::MD_RD;
                        n.sh = rd_reg(n.sh[5], n.sh[4:0], q, lpa, done);
                     end
                     else if (n.sh[11:10] == 2'b01)
                        n.mst = papc_pkg::MD_WR;
                  end
               end
            end
            papc_pkg::MD_RD:
            begin
               n.cnt = q.cnt + 6'h01;
               n.sdo = (q.cnt == 6'h00) ? 1'b0 : q.sh[15];
               if (q.cnt != 6'h00)
                  n.sh = {q.sh[14:0], 1'b0};
               if (q.cnt == papc_pkg::RD_LAST)
               begin
                  n.mst = papc_pkg::MD_PRE;
                  n.cnt = 6'h00;
               end
            end
            papc_pkg::MD_WR:
            begin
               n.cnt = q.cnt + 6'h01;
               if (q.cnt >= 6'h02)
                  n.sh = {q.sh[14:0], shared_serial_data_i};
               if (q.cnt == papc_pkg::WR_LAST)
               begin
                  n.mst = papc_pkg::MD_PRE;
                  n.cnt = 6'h00;
                  if (q.reg_a == papc_pkg::REG_CTRL)
                  begin
                     n.ctrl[q.port_sel] = n.sh;
                     n.ctrl[q.port_sel][papc_pkg::CTRL_RESTART] = 1'b0;
                     rs[q.port_sel] = n.sh[papc_pkg::CTRL_RESTART] & n.sh[papc_pkg::CTRL_NEG_EN];
                     n.restart = rs;
                  end
                  else if (q.reg_a == papc_pkg::REG_ADV)
                     n.adv[q.port_sel] = n.sh;
               end
            end
            default: n.mst = papc_pkg::MD_PRE;
         endcase
      end
      if (q.port_interface_choice || !q.rst_n)
         n.mst = papc_pkg::MD_PRE;
      // pin enables, low while driving; all released in reset
      n.oe_n[0] = !(n.rst_n && n.port_interface_choice);
      n.oe_n[1] = !(n.rst_n && n.port_interface_choice);
      n.oe_n[2] = !(n.rst_n && (n.port_interface_choice ||
                   (n.mst == papc_pkg::MD_RD && n.cnt != 6'h00)));
      for (int p = 0; p < 2; p++)
      begin
         logic [1:0] r;
         r = resolve(q.adv[p], lpa[p]);
         if (q.ctrl[p][papc_pkg::CTRL_NEG_EN])
         begin
            n.mode_speed[p] = r[1];
            n.mode_full[p] = r[0];
            n.mode_pause[p] = r[0] & q.adv[p][papc_pkg::ADV_PAUSE]
                              & lpa[p][papc_pkg::ADV_PAUSE];
         end
         else
         begin
            n.mode_speed[p] = q.ctrl[p][papc_pkg::CTRL_SPEED];
            n.mode_full[p] = q.ctrl[p][papc_pkg::CTRL_FULL];
            n.mode_pause[p] = q.ctrl[p][papc_pkg::CTRL_FULL] & q.adv[p][papc_pkg::ADV_PAUSE];
         end
      end
      n.xo_auto = auto_crossover_on;
      n.xo_forced = !auto_crossover_on & port0_manual_crossover;
      n.int_o = n.irq_pol ? n.irq_pend : !n.irq_pend;
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         q <= '0;
         q.oe_n <= 3'b111;
         q.int_o <= 1'b1;
         // the idle serial clock sits high; a low start value would fake a rising edge
         q.sdc_prev <= 1'b1;
      end
      else
      begin
         q <= n;
      end
   end

   for (genvar p = 0; p < 2; p++)
   begin : g_port
      papc_neg #(.BURST_CYC(BURST_CYC)) u_neg (
         .clock(clock),
         .rstn(rstn & q.rst_n),
         .neg_en(q.ctrl[p][papc_pkg::CTRL_NEG_EN]),
         .restart(q.restart[p]),
         .adv(q.adv[p]),
         .link_ok(link_ok[p]),
         .rx_valid(flp_rx_valid[p]),
         .rx_word(p == 0 ? flp_rx_word0 : flp_rx_word1),
         .tx_valid(flp_tx_valid[p]),
         .tx_word(lpa_tx[p]),
         .lpa(lpa[p]),
         .done(done[p])
      );
   end
   assign flp_tx_word0 = lpa_tx[0];
   assign flp_tx_word1 = lpa_tx[1];

   assign prom_select_iface_choice_o = q.ecs;
   assign prom_select_iface_choice_oe_n = q.oe_n[0];
   assign shared_serial_clock_o = q.eck;
   assign shared_serial_clock_oe_n = q.oe_n[1];
   assign shared_serial_data_o = q.port_interface_choice ? q.edi : q.sdo;
   assign shared_serial_data_oe_n = q.oe_n[2];
   assign port0_mode = '{q.mode_speed[0], q.mode_full[0], q.mode_pause[0]};
   assign port1_mode = '{q.mode_speed[1], q.mode_full[1], q.mode_pause[1]};
   assign crossover_auto = q.xo_auto;
   assign port0_crossover_forced = q.xo_forced;
   assign test_mode = q.test_mode;
   assign internal_reset_n = q.rst_n;
   assign interrupt_o = q.int_o;
   assign interrupt_oe_n = !q.rst_n;

   pins_float_a: assert property (@(posedge clock) disable iff (!rstn)
      !q.rst_n |-> q.oe_n == 3'b111) else $error("shared pin driven during reset");
   strap_catch_a: assert property (@(posedge clock) disable iff (!rstn)
      (q.rst_n && !q.rst_prev) |=> test_mode == $past(test_mode_strap))
      else $error("test strap not captured at reset release");
   slow_pref_a: assert property (@(posedge clock) disable iff (!rstn)
      (q.rst_n && !q.rst_prev && port1_pins.slow_pref) |=> q.adv[1][8:7] == 2'b00)
      else $error("100 Mbps advertised despite slow preference");
   forced_speed_a: assert property (@(posedge clock) disable iff (!rstn)
      (!q.ctrl[1][12] && $stable(q.ctrl[1])) |=> port1_mode.speed100 == $past(q.ctrl[1][13]))
      else $error("forced speed not applied");
   restart_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
      q.restart[0] |=> !q.restart[0] && !q.ctrl[0][9]) else $error("restart not self clearing");
   xover_ignore_a: assert property (@(posedge clock) disable iff (!rstn)
      auto_crossover_on |=> !port0_crossover_forced) else $error("manual crossover used in auto");
   int_level_a: assert property (@(posedge clock) disable iff (!rstn)
      q.rst_n |-> interrupt_o == (q.irq_pol ? q.irq_pend : !q.irq_pend))
      else $error("interrupt level wrong for polarity");
endmodule : papc_top

// ### papc_lp_model.sv
// behavioural link partner answering ability bursts on one port
`timescale 1ns/10ps
module papc_lp_model (
   input wire logic clock,
   input wire logic rstn,
   input wire logic tx_valid,
   input wire logic [15:0] ability,
   output logic rx_valid,
   output logic [15:0] rx_word
);
   logic seen_q;
   logic [1:0] wait_q;
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         seen_q <= 1'b0;
         wait_q <= 2'h0;
         rx_valid <= 1'b0;
         rx_word <= 16'h0000;
      end
      else
      begin
         rx_valid <= 1'b0;
         // outside a pulse the word is noise, never the last value
         rx_word <= ~rx_word;
         if (tx_valid)
            wait_q <= 2'h3;
         else if (wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
         if (wait_q == 2'h1)
         begin
            // acknowledge only once a first reply has already been sent
            rx_valid <= 1'b1;
            rx_word <= ability | {1'b0, seen_q, 14'h0000};
            seen_q <= 1'b1;
         end
      end
   end
endmodule : papc_lp_model

// ### test_papc_top.sv
// self-checking bench for the negotiation and configuration block
`timescale 1ns/10ps
module test_papc_top;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic rc = 1'b0;
   logic sck = 1'b1;
   logic sdo = 1'b1;
   logic xo_auto = 1'b1;
   logic ts = 1'b0;
   logic pdr = 1'b0;
   logic mx = 1'b1;
   logic cs_pull = 1'b0;
   logic [1:0] lk = 2'b11;
   logic tx1_seen = 1'b0;
   logic [15:0] w1 = 16'h0000;
   int fail_count = 0;
   int tests_run = 0;
   logic cs_o, cs_oe_n, ck_o, ck_oe_n, sd_o, sd_oe_n, cs, ck, sd;
   logic xa, xf, tm, irn, irq, irq_oe_n;
   logic [1:0] rxv, txv;
   logic [15:0] rxw0, rxw1, txw0, txw1;
   papc_pkg::papc_mode_s m0, m1;
   // pins float to their pull levels when released
   assign cs = cs_oe_n ? cs_pull : cs_o;
   assign ck = ck_oe_n ? sck : ck_o;
   assign sd = sd_oe_n ? sdo : sd_o;
   always #2.5 clock = ~clock;
   always @(posedge clock)
   begin
      if (txv[1] & ~tx1_seen)
         w1 <= txw1;
      if (txv[1])
         tx1_seen <= 1'b1;
   end
   papc_top #(.BURST_CYC(64)) dut (.clock(clock), .rstn(rstn), .power_on_rc_input(rc),
      .test_mode_strap(ts), .prom_select_iface_choice_i(cs), .prom_select_iface_choice_o(cs_o),
      .prom_select_iface_choice_oe_n(cs_oe_n), .shared_serial_clock_i(ck),
      .shared_serial_clock_o(ck_o), .shared_serial_clock_oe_n(ck_oe_n),
      .shared_serial_data_i(sd), .shared_serial_data_o(sd_o), .shared_serial_data_oe_n(sd_oe_n),
      .prom_data_return(pdr), .port0_pins(4'h0), .port1_pins(4'ha),
      .auto_crossover_on(xo_auto), .port0_manual_crossover(mx), .link_ok(lk),
      .flp_rx_valid(rxv), .flp_rx_word0(rxw0), .flp_rx_word1(rxw1), .flp_tx_valid(txv),
      .flp_tx_word0(txw0), .flp_tx_word1(txw1), .port0_mode(m0), .port1_mode(m1),
      .crossover_auto(xa), .port0_crossover_forced(xf), .test_mode(tm),
      .internal_reset_n(irn), .interrupt_o(irq), .interrupt_oe_n(irq_oe_n));
   papc_lp_model lp0 (.clock(clock), .rstn(rstn), .tx_valid(txv[0]), .ability(16'h00e1),
      .rx_valid(rxv[0]), .rx_word(rxw0));
   papc_lp_model lp1 (.clock(clock), .rstn(rstn), .tx_valid(txv[1]), .ability(16'h01e1),
      .rx_valid(rxv[1]), .rx_word(rxw1));
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one serial bit: device data changes after a rise, so it is taken just before the next rise
   task sbit(input logic b, output logic r);
      @(posedge clock);
      sck <= 1'b0;
      sdo <= b;
      repeat (2) @(posedge clock);
      #1 r = sd;
      @(posedge clock);
      sck <= 1'b1;
      repeat (4) @(posedge clock);
   endtask : sbit
   task frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
      input logic [15:0] wd, output logic [15:0] rd);
      logic r;
      logic [13:0] hdr;
      logic [17:0] tail;
      hdr = {2'b01, op, phy, rg};
      tail = (op == 2'b01) ? {2'b10, wd} : 18'h3ffff;
      for (int i = 0; i < 32; i++)
         sbit(1'b1, r);
      for (int i = 13; i >= 0; i--)
         sbit(hdr[i], r);
      for (int i = 17; i >= 0; i--)
      begin
         sbit(tail[i], r);
         rd = {rd[14:0], r};
      end
   endtask : frame
   task test_reset;
      repeat (4) @(posedge clock);
      #1 check("oe in reset", {13'h0000, cs_oe_n, ck_oe_n, sd_oe_n}, 16'h0007);
      @(posedge clock) rstn <= 1'b1;
      repeat (2) @(posedge clock);
      #1 check("oe in int reset", {12'h000, cs_oe_n, ck_oe_n, sd_oe_n, irn}, 16'h000e);
      @(posedge clock) rc <= 1'b1;
      @(posedge clock);
      #1 check("int reset early", {15'h0000, irn}, 16'h0000);
      @(posedge clock);
      #1 check("int reset", {15'h0000, irn}, 16'h0001);
      for (int i = 0; i < 20 && txv[0] !== 1'b1; i++)
         #5;
      check("tx0", {txv[0], txw0[14:0]}, {1'b1, papc_pkg::ADV_RESET[14:0]});
      #5 check("straps", {12'h000, cs_oe_n, tm, xa, xf}, 16'h000a);
      @(posedge clock) xo_auto <= 1'b0;
      repeat (3) @(posedge clock);
      #1 check("manual crossover", {14'h0000, xa, xf}, 16'h0001);
      $display("test reset done");
   endtask : test_reset
   task test_negotiate;
      logic [15:0] rd;
      repeat (100) @(posedge clock);
      #1 check("irq pending", {15'h0000, irq}, 16'h0000);
      frame(2'b10, 5'h10, 5'h01, 16'h0000, rd);
      check("status port0", rd & 16'hf83d, 16'hf82d);
      check("irq cleared", {15'h0000, irq}, 16'h0001);
      frame(2'b10, 5'h10, 5'h05, 16'h0000, rd);
      check("partner word", rd & 16'hbfff, 16'h00e1);
      check("mode port0", {13'h0000, m0}, 16'h0004);
      check("irq enable", {15'h0000, irq_oe_n}, 16'h0000);
      frame(2'b01, 5'h10, 5'h00, 16'h1200, rd);
      frame(2'b10, 5'h10, 5'h00, 16'h0000, rd);
      check("restart clears", rd, 16'h1000);
      check("irq on renegotiation", {15'h0000, irq}, 16'h0000);
      $display("test negotiate done");
   endtask : test_negotiate
   task test_forced;
      logic [15:0] rd;
      check("port1 silent", {15'h0000, tx1_seen}, 16'h0000);
      check("mode port1", {13'h0000, m1} & 16'h0006, 16'h0002);
      frame(2'b10, 5'h11, 5'h1f, 16'h0000, rd);
      check("unmapped", rd, 16'h0000);
      frame(2'b01, 5'h11, 5'h00, 16'h1000, rd);
      for (int i = 0; i < 90 && tx1_seen !== 1'b1; i++)
         #5;
      check("tx1", {tx1_seen, w1[14:0]}, 16'h8461);
      $display("test forced done");
   endtask : test_forced
   // internal reset again, this time with the select pin pulled high so the PROM is read
   task test_prom;
      @(posedge clock) rc <= 1'b0;
      repeat (3) @(posedge clock);
      #1 check("oe in mid reset", {12'h000, cs_oe_n, ck_oe_n, sd_oe_n, irq_oe_n}, 16'h000f);
      @(posedge clock)
      begin
         cs_pull <= 1'b1;
         ts <= 1'b1;
         pdr <= 1'b1;
         rc <= 1'b1;
      end
      repeat (4) @(posedge clock);
      #1 check("prom start", {10'h000, cs_oe_n, cs, ck_oe_n, ck, sd_oe_n, sd}, 16'h0011);
      check("strap test", {15'h0000, tm}, 16'h0001);
      repeat (200) @(posedge clock);
      #1 check("prom clock", {15'h0000, ck}, 16'h0001);
      repeat (9800) @(posedge clock);
      #1 check("prom end", {13'h0000, cs_oe_n, cs, irq}, 16'h0001);
      $display("test prom done");
   endtask : test_prom
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      test_reset();
      test_negotiate();
      test_forced();
      test_prom();
      give_verdict();
   end
   // tests take about 13,200 cycles, most of them the PROM read
   initial
   begin
      #150000;
      fail_count++;
      give_verdict();
   end
endmodule : test_papc_top
